//--- hw/bclu_defines.svh
// Register map, field positions and constants of the branch condition loop unit
`ifndef BCLU_DEFINES_SVH
`define BCLU_DEFINES_SVH
`define BCLU_AW          8
`define BCLU_A_CTRL      8'h00
`define BCLU_A_FLAGS     8'h04
`define BCLU_A_CNT_LO    8'h08
`define BCLU_A_CNT_HI    8'h0C
`define BCLU_A_IP_LO     8'h10
`define BCLU_A_IP_HI     8'h14
`define BCLU_A_DISP      8'h18
`define BCLU_A_CMD       8'h1C
`define BCLU_A_BVAL      8'h20
`define BCLU_A_BLO       8'h24
`define BCLU_A_BHI       8'h28
`define BCLU_A_STAT      8'h2C
`define BCLU_CTRL_LONG   0
`define BCLU_CTRL_COMPAT 1
`define BCLU_CTRL_ASZ    3:2
`define BCLU_CTRL_MASK   32'h0000000F
`define BCLU_F_CARRY     0
`define BCLU_F_PARITY    2
`define BCLU_F_ZERO      6
`define BCLU_F_SIGN      7
`define BCLU_F_OVER      11
`define BCLU_FLAGS_MASK  32'h000008C5
`define BCLU_CMD_OP      3:0
`define BCLU_CMD_CC      7:4
`define BCLU_CMD_VEC     15:8
`define BCLU_CMD_LEN     19:16
`define BCLU_CMD_CPLCHG  20
`define BCLU_ST_TAKEN    0
`define BCLU_ST_EXC      1
`define BCLU_ST_POPSTK   2
`define BCLU_ST_POPSZ    7:4
`define BCLU_ST_VEC      15:8
`define BCLU_VEC_OVER    8'h04
`define BCLU_VEC_RANGE   8'h05
`define BCLU_VEC_UNSUP   8'h06
`define BCLU_POP_WIDE    4'h8
`define BCLU_POP_NARROW  4'h4
`define BCLU_RESP_OKAY   2'h0
`define BCLU_RESP_SLVERR 2'h2
`define BCLU_LOOP_WRAP32 32'hFFFFFFFF
`endif

//--- hw/bclu_pkg.sv
// Types of the branch condition loop unit
`default_nettype none
package bclu_pkg;
    typedef enum logic [3:0] {
        OP_NONE   = 4'h0,
        OP_JCC    = 4'h1,
        OP_JCZ    = 4'h2,
        OP_LOOP   = 4'h3,
        OP_LOOPE  = 4'h4,
        OP_LOOPNE = 4'h5,
        OP_INTN   = 4'h6,
        OP_INTO   = 4'h7,
        OP_RANGE  = 4'h8,
        OP_INTERRUPT_RETURN   = 4'h9
    } bclu_op_t;
    // One selector per distinct flag test; alternate names share an encoding
    typedef enum logic [3:0] {
        CC_O  = 4'h0, CC_NO = 4'h1, CC_B  = 4'h2, CC_AE = 4'h3,
        CC_E  = 4'h4, CC_NE = 4'h5, CC_BE = 4'h6, CC_A  = 4'h7,
        CC_S  = 4'h8, CC_NS = 4'h9, CC_P  = 4'hA, CC_NP = 4'hB,
        CC_L  = 4'hC, CC_GE = 4'hD, CC_LE = 4'hE, CC_G  = 4'hF
    } bclu_cc_t;
    typedef enum logic [1:0] {
        ASZ_16 = 2'h0,
        ASZ_32 = 2'h1,
        ASZ_64 = 2'h2
    } bclu_asz_t;
    typedef enum logic [1:0] {
        WS_IDLE = 2'b00,
        WS_AW   = 2'b01,
        WS_RESP = 2'b11,
        WS_W    = 2'b10
    } bclu_wst_t;
endpackage : bclu_pkg
`default_nettype wire

//--- hw/bclu_branch_unit.sv
// Branch condition, counted loop and software interrupt unit with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
`include "bclu_defines.svh"

// Overview of operation
// - False predicate falls through; true redirects, no link
// - Above needs carry and zero clear
// - Above-or-equal carry clear; below carry set
// - Parity even on parity set, odd clear
// - Single flag tests and their negations
// - Greater: zero clear, sign equals overflow
// - Greater-or-equal and less from sign xor overflow
// - Less-or-equal when xor or zero set
// - Count-zero jump tests count, narrow in 16-bit
// - Target is pointer plus sign-extended displacement
// - Loop decrements count then branches if nonzero
// - Zero count wraps to all ones
// - Loop-while-equal needs nonzero count and zero set
// - Loop-while-unequal needs nonzero count, zero clear
// - Long mode near branches use full pointer
// - Long mode displacement 32 bits sign-extended
// - Address size picks count width, long default
// - Software interrupt raises encoded vector
// - Overflow trap only when overflow set
// - Range check faults outside signed bounds
// - Long mode return pops wide, always stack
// - Compat return pops stack on privilege change
module bclu_branch_unit
    import bclu_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 ce,
    // AXI4-Lite write address and data
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [`BCLU_AW-1:0]  s_axi_awaddr,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    // AXI4-Lite write response
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    output logic [1:0]                s_axi_bresp,
    // AXI4-Lite read
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    input  wire logic [`BCLU_AW-1:0]  s_axi_araddr,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    // Exception event
    output logic                      excRaise,
    output logic [7:0]                excVector
);

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    function automatic logic cond_eval(input logic [3:0] cc, input logic [31:0] fl);
        logic cf;
        logic pf;
        logic zf;
        logic sf;
        logic vf;
        logic res;
        cf = fl[`BCLU_F_CARRY];
        pf = fl[`BCLU_F_PARITY];
        zf = fl[`BCLU_F_ZERO];
        sf = fl[`BCLU_F_SIGN];
        vf = fl[`BCLU_F_OVER];
        case (cc)
            CC_O:    res = vf;
            CC_NO:   res = ~vf;
            CC_B:    res = cf;
            CC_AE:   res = ~cf;
            CC_E:    res = zf;
            CC_NE:   res = ~zf;
            CC_BE:   res = cf | zf;
            CC_A:    res = ~(cf | zf);
            CC_S:    res = sf;
            CC_NS:   res = ~sf;
            CC_P:    res = pf;
            CC_NP:   res = ~pf;
            CC_L:    res = sf ^ vf;
            CC_GE:   res = ~(sf ^ vf);
            CC_LE:   res = (sf ^ vf) | zf;
            CC_G:    res = ~((sf ^ vf) | zf);
            default: res = 1'b0;
        endcase
        return res;
    endfunction : cond_eval

    function automatic logic cnt_zero(input logic [63:0] c, input logic [1:0] asz);
        logic res;
        case (asz)
            ASZ_16:  res = (c[15:0] == 16'h0000);
            ASZ_32:  res = (c[31:0] == 32'h00000000);
            default: res = (c == 64'h0000000000000000);
        endcase
        return res;
    endfunction : cnt_zero

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0]  ctrl_ff;
    logic [31:0]  flags_ff;
    logic [63:0]  count_ff;
    logic [63:0]  ip_ff;
    logic [31:0]  disp_ff;
    logic [31:0]  bval_ff;
    logic [31:0]  blo_ff;
    logic [31:0]  bhi_ff;
    logic [31:0]  stat_ff;
    bclu_wst_t    wst_ff;
    logic [`BCLU_AW-1:0] wAddr_ff;
    logic [31:0]  wData_ff;
    logic [3:0]   wStrb_ff;
    logic         awready_ff;
    logic         wready_ff;
    logic         bvalid_ff;
    logic [1:0]   bresp_ff;
    logic         arready_ff;
    logic         rvalid_ff;
    logic [31:0]  rdata_ff;
    logic [1:0]   rresp_ff;
    logic         excRaise_ff;
    logic [7:0]   excVector_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel handshake; frozen edges take nothing
    bclu_wst_t    nxt_wst;
    wire          awFire = ce & s_axi_awvalid & awready_ff;
    wire          wFire  = ce & s_axi_wvalid & wready_ff;
    wire          bFire  = ce & bvalid_ff & s_axi_bready;
    wire          arFire = ce & s_axi_arvalid & arready_ff;
    wire          rFire  = ce & rvalid_ff & s_axi_rready;

    always_comb begin
        nxt_wst = wst_ff;
        case (wst_ff)
            WS_IDLE: begin
                if (awFire && wFire) begin
                    nxt_wst = WS_RESP;
                end else if (awFire) begin
                    nxt_wst = WS_AW;
                end else if (wFire) begin
                    nxt_wst = WS_W;
                end
            end
            WS_AW:   nxt_wst = wFire ? WS_RESP : WS_AW;
            WS_W:    nxt_wst = awFire ? WS_RESP : WS_W;
            WS_RESP: nxt_wst = bFire ? WS_IDLE : WS_RESP;
            default: nxt_wst = WS_IDLE;
        endcase
    end

    wire               doWrite  = (nxt_wst == WS_RESP) && (wst_ff != WS_RESP);
    wire [`BCLU_AW-1:0] wAddr   = awFire ? s_axi_awaddr : wAddr_ff;
    wire [31:0]        wData    = wFire ? s_axi_wdata : wData_ff;
    wire [3:0]         wStrb    = wFire ? s_axi_wstrb : wStrb_ff;
    wire               wMapped  = (wAddr[1:0] == 2'b00) && (wAddr <= `BCLU_A_STAT);
    wire               wrCtrl   = doWrite && (wAddr == `BCLU_A_CTRL);
    wire               wrFlags  = doWrite && (wAddr == `BCLU_A_FLAGS);
    wire               wrCntLo  = doWrite && (wAddr == `BCLU_A_CNT_LO);
    wire               wrCntHi  = doWrite && (wAddr == `BCLU_A_CNT_HI);
    wire               wrIpLo   = doWrite && (wAddr == `BCLU_A_IP_LO);
    wire               wrIpHi   = doWrite && (wAddr == `BCLU_A_IP_HI);
    wire               wrDisp   = doWrite && (wAddr == `BCLU_A_DISP);
    wire               wrBval   = doWrite && (wAddr == `BCLU_A_BVAL);
    wire               wrBlo    = doWrite && (wAddr == `BCLU_A_BLO);
    wire               wrBhi    = doWrite && (wAddr == `BCLU_A_BHI);
    wire               execNow  = doWrite && (wAddr == `BCLU_A_CMD);
    wire [31:0]        cmd      = merge_bytes(32'h00000000, wData, wStrb);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wst_ff     <= WS_IDLE;
            wAddr_ff   <= '0;
            wData_ff   <= 32'h00000000;
            wStrb_ff   <= 4'h0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `BCLU_RESP_OKAY;
        end else if (ce) begin
            wst_ff     <= nxt_wst;
            wAddr_ff   <= wAddr;
            wData_ff   <= wData;
            wStrb_ff   <= wStrb;
            awready_ff <= (nxt_wst == WS_IDLE) || (nxt_wst == WS_W);
            wready_ff  <= (nxt_wst == WS_IDLE) || (nxt_wst == WS_AW);
            bvalid_ff  <= (nxt_wst == WS_RESP);
            if (doWrite) begin
                bresp_ff <= wMapped ? `BCLU_RESP_OKAY : `BCLU_RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel
    wire [`BCLU_AW-1:0] rA = s_axi_araddr;
    wire          rMapped  = (rA[1:0] == 2'b00) && (rA <= `BCLU_A_STAT);
    wire [31:0]   rdMux    = (rA == `BCLU_A_CTRL)   ? ctrl_ff        :
                             (rA == `BCLU_A_FLAGS)  ? flags_ff       :
                             (rA == `BCLU_A_CNT_LO) ? count_ff[31:0] :
                             (rA == `BCLU_A_CNT_HI) ? count_ff[63:32] :
                             (rA == `BCLU_A_IP_LO)  ? ip_ff[31:0]    :
                             (rA == `BCLU_A_IP_HI)  ? ip_ff[63:32]   :
                             (rA == `BCLU_A_DISP)   ? disp_ff        :
                             (rA == `BCLU_A_BVAL)   ? bval_ff        :
                             (rA == `BCLU_A_BLO)    ? blo_ff         :
                             (rA == `BCLU_A_BHI)    ? bhi_ff         :
                             (rA == `BCLU_A_STAT)   ? stat_ff        : 32'h00000000;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h00000000;
            rresp_ff   <= `BCLU_RESP_OKAY;
        end else if (arFire) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rdMux;
            rresp_ff   <= rMapped ? `BCLU_RESP_OKAY : `BCLU_RESP_SLVERR;
        end else if (rFire) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Branch resolution; a command word executes on the edge that completes its write
    wire          longMode  = ctrl_ff[`BCLU_CTRL_LONG];
    wire          compat    = ctrl_ff[`BCLU_CTRL_COMPAT];
    wire [1:0]    aszReq    = ctrl_ff[`BCLU_CTRL_ASZ];
    // Long mode: 64 unless reduced to 32; elsewhere 64 is not reachable
    wire [1:0]    aszEff    = longMode ? ((aszReq == ASZ_32) ? ASZ_32 : ASZ_64)
                                       : ((aszReq == ASZ_16) ? ASZ_16 : ASZ_32);
    wire [3:0]    cmdOp     = cmd[`BCLU_CMD_OP];
    wire [3:0]    cmdCc     = cmd[`BCLU_CMD_CC];
    wire          zf        = flags_ff[`BCLU_F_ZERO];
    wire          vf        = flags_ff[`BCLU_F_OVER];
    wire [63:0]   dec64     = count_ff - 64'h0000000000000001;
    wire [31:0]   dec32     = count_ff[31:0] - 32'h00000001;
    wire [15:0]   dec16     = count_ff[15:0] - 16'h0001;
    // Narrower sizes leave the upper count bits untouched
    wire [63:0]   cntDec    = (aszEff == ASZ_16) ? {count_ff[63:16], dec16} :
                              (aszEff == ASZ_32) ? {count_ff[63:32], dec32} : dec64;
    wire          decZero   = cnt_zero(cntDec, aszEff);
    wire          condTrue  = cond_eval(cmdCc, flags_ff);
    wire          isLoop    = (cmdOp == OP_LOOP) || (cmdOp == OP_LOOPE) || (cmdOp == OP_LOOPNE);
    wire          takeBr    = (cmdOp == OP_JCC)    ? condTrue :
                              (cmdOp == OP_JCZ)    ? cnt_zero(count_ff, aszEff) :
                              (cmdOp == OP_LOOP)   ? ~decZero :
                              (cmdOp == OP_LOOPE)  ? (~decZero & zf) :
                              (cmdOp == OP_LOOPNE) ? (~decZero & ~zf) : 1'b0;
    wire [63:0]   sDisp     = {{32{disp_ff[31]}}, disp_ff};
    wire [63:0]   ilen      = {60'h0, cmd[`BCLU_CMD_LEN]};
    wire [63:0]   seqRaw    = ip_ff + ilen;
    wire [63:0]   tgtRaw    = seqRaw + sDisp;
    // Full pointer in long mode, 32-bit pointer otherwise
    wire [63:0]   seqIp     = longMode ? seqRaw : {32'h00000000, seqRaw[31:0]};
    wire [63:0]   targetIp  = longMode ? tgtRaw : {32'h00000000, tgtRaw[31:0]};
    wire [63:0]   nxtIp     = takeBr ? targetIp : seqIp;
    wire          belowLo   = $signed(bval_ff) < $signed(blo_ff);
    wire          aboveHi   = $signed(bval_ff) > $signed(bhi_ff);
    wire          rangeExc  = longMode | belowLo | aboveHi;
    wire [7:0]    rangeVec  = longMode ? `BCLU_VEC_UNSUP : `BCLU_VEC_RANGE;
    wire          excHit    = (cmdOp == OP_INTN) ||
                              ((cmdOp == OP_INTO) && vf) ||
                              ((cmdOp == OP_RANGE) && rangeExc);
    wire [7:0]    excVec    = (cmdOp == OP_INTN) ? cmd[`BCLU_CMD_VEC] :
                              (cmdOp == OP_INTO) ? `BCLU_VEC_OVER : rangeVec;
    wire          isRet     = (cmdOp == OP_INTERRUPT_RETURN);
    wire          popStk    = longMode | (compat & cmd[`BCLU_CMD_CPLCHG]);
    wire [3:0]    popSize   = longMode ? `BCLU_POP_WIDE : `BCLU_POP_NARROW;
    wire          updIp     = (cmdOp == OP_JCC) || (cmdOp == OP_JCZ) || isLoop;
    wire [31:0]   nxtStat   = {16'h0000, excVec & {8{excHit}}, popSize & {4{isRet}},
                               1'b0, popStk & isRet, excHit, takeBr};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff  <= 32'h00000000;
            flags_ff <= 32'h00000000;
            disp_ff  <= 32'h00000000;
            bval_ff  <= 32'h00000000;
            blo_ff   <= 32'h00000000;
            bhi_ff   <= 32'h00000000;
        end else if (ce) begin
            if (wrCtrl)  ctrl_ff  <= merge_bytes(ctrl_ff, wData, wStrb) & `BCLU_CTRL_MASK;
            if (wrFlags) flags_ff <= merge_bytes(flags_ff, wData, wStrb) & `BCLU_FLAGS_MASK;
            if (wrDisp)  disp_ff  <= merge_bytes(disp_ff, wData, wStrb);
            if (wrBval)  bval_ff  <= merge_bytes(bval_ff, wData, wStrb);
            if (wrBlo)   blo_ff   <= merge_bytes(blo_ff, wData, wStrb);
            if (wrBhi)   bhi_ff   <= merge_bytes(bhi_ff, wData, wStrb);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_ff <= 64'h0000000000000000;
            ip_ff    <= 64'h0000000000000000;
        end else if (ce) begin
            if (execNow && isLoop) count_ff <= cntDec;
            if (wrCntLo) count_ff[31:0]  <= merge_bytes(count_ff[31:0], wData, wStrb);
            if (wrCntHi) count_ff[63:32] <= merge_bytes(count_ff[63:32], wData, wStrb);
            if (execNow && updIp) ip_ff <= nxtIp;
            if (wrIpLo)  ip_ff[31:0]  <= merge_bytes(ip_ff[31:0], wData, wStrb);
            if (wrIpHi)  ip_ff[63:32] <= merge_bytes(ip_ff[63:32], wData, wStrb);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stat_ff      <= 32'h00000000;
            excRaise_ff  <= 1'b0;
            excVector_ff <= 8'h00;
        end else if (ce) begin
            excRaise_ff <= execNow & excHit;
            if (execNow) begin
                stat_ff <= nxtStat;
            end
            if (execNow && excHit) begin
                excVector_ff <= excVec;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign excRaise      = excRaise_ff;
    assign excVector     = excVector_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_jcc_issue;
        execNow && (cmdOp == OP_JCC);
    endsequence
    sequence s_loop_issue;
        execNow && isLoop;
    endsequence

    a_jcc_taken_ip: assert property (@(posedge clk) disable iff (!nrst)
        s_jcc_issue and condTrue |=> ip_ff == $past(targetIp))
        else $error("taken jump did not reach target");
    a_jcc_fall_ip: assert property (@(posedge clk) disable iff (!nrst)
        s_jcc_issue and !condTrue |=> ip_ff == $past(seqIp))
        else $error("untaken jump did not fall through");
    a_above_cond: assert property (@(posedge clk) disable iff (!nrst)
        s_jcc_issue and (cmdCc == CC_A) |-> condTrue == !(flags_ff[`BCLU_F_CARRY] | zf))
        else $error("above predicate wrong");
    a_greater_cond: assert property (@(posedge clk) disable iff (!nrst)
        s_jcc_issue and (cmdCc == CC_G) |-> condTrue == (!zf && (flags_ff[`BCLU_F_SIGN] == vf)))
        else $error("greater predicate wrong");
    a_loop_wrap_count: assert property (@(posedge clk) disable iff (!nrst)
        s_loop_issue and (aszEff == ASZ_32) and (count_ff[31:0] == 32'h00000000)
        |=> count_ff[31:0] == `BCLU_LOOP_WRAP32)
        else $error("loop count did not wrap");
    a_loope_exit_ip: assert property (@(posedge clk) disable iff (!nrst)
        s_loop_issue and (cmdOp == OP_LOOPE) and !zf |=> ip_ff == $past(seqIp))
        else $error("loop while equal did not exit");
    a_narrow_ip_high: assert property (@(posedge clk) disable iff (!nrst)
        s_jcc_issue and !longMode |=> ip_ff[63:32] == 32'h00000000)
        else $error("pointer not truncated outside long mode");
    a_into_quiet: assert property (@(posedge clk) disable iff (!nrst)
        execNow && (cmdOp == OP_INTO) && !vf |=> !excRaise_ff ##1 !excRaise_ff)
        else $error("overflow trap raised with flag clear");
    a_range_long_unsup: assert property (@(posedge clk) disable iff (!nrst)
        execNow && (cmdOp == OP_RANGE) && longMode |=> excRaise_ff && (excVector_ff == `BCLU_VEC_UNSUP))
        else $error("range check not unsupported in long mode");
    a_interrupt_return_compat_pop: assert property (@(posedge clk) disable iff (!nrst)
        execNow && isRet && compat && !longMode |=> stat_ff[`BCLU_ST_POPSTK] == $past(cmd[`BCLU_CMD_CPLCHG]))
        else $error("compat return stack pop wrong");

endmodule : bclu_branch_unit
`default_nettype wire

//--- test/branch_condition_loop_unit_bench.sv
// Self-checking bench of the branch condition loop unit
`timescale 1ns/100ps
`default_nettype none
module branch_condition_loop_unit_bench;
    logic        clk = 1'b0, nrst = 1'b0, awV = 1'b0, wV = 1'b0, bR = 1'b0, arV = 1'b0, rR = 1'b0;
    logic [7:0]  awA = 8'h00, arA = 8'h00, vec;
    logic [31:0] wD = 32'h0, rd, st;
    logic        aw, w, bV, ar, rV, exc, excR;
    logic [1:0]  rRsp, rs, bRsp, ws;
    int          errors = 0, comparisons = 0;
    always #12.5 clk = ~clk;
    bclu_branch_unit u_bclu_branch_unit (.clk(clk), .nrst(nrst), .ce(1'b1), .s_axi_awvalid(awV),
        .s_axi_awready(aw), .s_axi_awaddr(awA), .s_axi_wvalid(wV), .s_axi_wready(w), .s_axi_wdata(wD),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_bresp(bRsp), .s_axi_arvalid(arV),
        .s_axi_arready(ar), .s_axi_araddr(arA), .s_axi_rvalid(rV), .s_axi_rready(rR), .s_axi_rdata(rd),
        .s_axi_rresp(rRsp), .excRaise(excR), .excVector(vec));
////////////////////////////////////////////////////////////////
    // Values read after an edge are the ones sampled by it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awA <= a;
        wD <= d;
        awV <= 1'b1;
        wV <= 1'b1;
        bR <= 1'b1;
        do begin
            @(posedge clk);
            if (aw) awV <= 1'b0;
            if (w) wV <= 1'b0;
        end while (bV !== 1'b1);
        exc = excR;
        ws = bRsp;
        bR <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        arA <= a;
        arV <= 1'b1;
        rR <= 1'b1;
        do begin
            @(posedge clk);
            if (ar) arV <= 1'b0;
        end while (rV !== 1'b1);
        st = rd;
        rs = rRsp;
        rR <= 1'b0;
    endtask : rdr
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic ex(input logic [31:0] c0, f, input logic [7:0] a, input logic [31:0] v, c);
        wr(8'h00, c0);
        wr(8'h04, f);
        wr(a, v);
        wr(8'h1C, c);
        rdr(8'h2C);
    endtask : ex
    function automatic logic pr(input logic [3:0] c, input logic [31:0] f);
        logic [7:0] t;
        t = {f[11] ^ f[7] | f[6], f[11] ^ f[7], f[2], f[7], f[0] | f[6], f[6], f[0], f[11]};
        return t[c[3:1]] ^ c[0];
    endfunction : pr
////////////////////////////////////////////////////////////////
    task automatic t_cc();
        logic [31:0] fl [4] = '{32'h0, 32'h8C5, 32'h80, 32'h841};
        logic        tk;
        wr(8'h18, 32'hFFFFFFF0);
        for (int i = 0; i < 64; i++) begin
            tk = pr(i[3:0], fl[i/16]);
            ex(32'h4, fl[i/16], 8'h10, 32'h1000, {12'h0, 4'h2, 8'h0, i[3:0], 4'h1});
            chk("taken", {31'h0, tk}, st & 32'h1);
            rdr(8'h10);
            chk("ip", tk ? 32'hFF2 : 32'h1002, st);
        end
        wr(8'h14, 32'h2);
        ex(32'h1, 32'h800, 8'h10, 32'h4, 32'h00020001);
        rdr(8'h14);
        chk("iphi", 32'h1, st);
        rdr(8'h10);
        chk("iplo", 32'hFFFFFFF6, st);
        $display("t_cc done");
    endtask : t_cc
    task automatic t_loop();
        logic [31:0] r [9][6] = '{'{32'h4, 32'h0, 32'h0, 32'h3, 32'h1, 32'hFFFFFFFF},
            '{32'h4, 32'h0, 32'h1, 32'h3, 32'h0, 32'h0}, '{32'h0, 32'h0, 32'h10001, 32'h3, 32'h0, 32'h10000},
            '{32'h0, 32'h0, 32'h50000, 32'h2, 32'h1, 32'h50000}, '{32'h4, 32'h0, 32'h3, 32'h4, 32'h0, 32'h2},
            '{32'h4, 32'h40, 32'h3, 32'h4, 32'h1, 32'h2}, '{32'h4, 32'h0, 32'h3, 32'h5, 32'h1, 32'h2},
            '{32'h4, 32'h40, 32'h3, 32'h5, 32'h0, 32'h2}, '{32'h1, 32'h0, 32'h0, 32'h3, 32'h1, 32'hFFFFFFFF}};
        foreach (r[i]) begin
            ex(r[i][0], r[i][1], 8'h08, r[i][2], r[i][3]);
            chk("taken", r[i][4], st & 32'h1);
            rdr(8'h08);
            chk("cntlo", r[i][5], st);
            rdr(8'h0C);
            chk("cnthi", i == 8 ? 32'hFFFFFFFF : 32'h0, st);
        end
        $display("t_loop done");
    endtask : t_loop
    task automatic t_exc();
        logic [31:0] r [10][5] = '{'{32'h4, 32'h800, 32'h0, 32'h7, 32'h402}, '{32'h4, 32'h0, 32'h0, 32'h7, 32'h0},
            '{32'h4, 32'h0, 32'h0, 32'h2106, 32'h2102}, '{32'h4, 32'h0, 32'hFFFFFFFF, 32'h8, 32'h502},
            '{32'h4, 32'h0, 32'h6, 32'h8, 32'h502}, '{32'h4, 32'h0, 32'h5, 32'h8, 32'h0},
            '{32'h1, 32'h0, 32'h5, 32'h8, 32'h602}, '{32'h1, 32'h0, 32'h5, 32'h9, 32'h84},
            '{32'h2, 32'h0, 32'h5, 32'h100009, 32'h44}, '{32'h2, 32'h0, 32'h5, 32'h9, 32'h40}};
        wr(8'h24, 32'h0);
        wr(8'h28, 32'h5);
        chk("bresp", 32'h0, {30'h0, ws});
        foreach (r[i]) begin
            ex(r[i][0], r[i][1], 8'h20, r[i][2], r[i][3]);
            chk("stat", r[i][4], st & {16'h0, r[i][4][1] ? 8'hFF : 8'h00, 8'hFF});
            chk("exc", {31'h0, r[i][4][1]}, {31'h0, exc});
        end
        chk("vec", 32'h6, {24'h0, vec});
        rdr(8'h30);
        chk("rresp", 32'h2, {30'h0, rs});
        wr(8'h30, 32'h0);
        chk("bresp", 32'h2, {30'h0, ws});
        $display("t_exc done");
    endtask : t_exc
////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        t_cc();
        t_loop();
        t_exc();
        end_sim();
    end
    initial begin
        #1000000;
        errors++;
        end_sim();
    end
endmodule : branch_condition_loop_unit_bench
`default_nettype wire
